// File: design/afs_pkg.sv
// constants and carrier types of the analog output fallback selector
// assumes one 200 MHz clock and an AXI4-Lite register master
// Notes on behaviour
// - voltage starts at power-up choice until first measurement
// - current starts at power-up choice until first measurement
// - no-target timeout sets voltage low, high or hold
// - no-target timeout sets current independently low/high/hold
// - no-target delay counts uninterrupted absence, 5 ms steps
// - follower without sync sets voltage per option
// - follower without sync sets current per option
// - one shared no-sync delay, default zero
`default_nettype none
package afs_pkg;
  localparam int unsigned CLK_HZ        = 200000000;
  localparam int unsigned STEP_US       = 5000;
  localparam int unsigned STEP_CYCLES   = (CLK_HZ / 1000000) * STEP_US;
  localparam int unsigned DELAY_W       = 16;
  localparam logic [DELAY_W-1:0] DELAY_MAX = 16'hFFFF;
  // 5.46 minutes in 5 ms steps
  localparam logic [DELAY_W-1:0] NT_DELAY_LIMIT = 16'hFFF0;
  localparam logic [DELAY_W-1:0] NT_DELAY_RST   = 16'h0000;
  localparam logic [DELAY_W-1:0] NS_DELAY_RST   = 16'h0000;

  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_NTDLY   = 8'h04;
  localparam logic [7:0] OFF_NSDLY   = 8'h08;
  localparam logic [7:0] OFF_STATUS  = 8'h0C;
  localparam logic [7:0] OFF_IRQ_ST  = 8'h10;
  localparam logic [7:0] OFF_IRQ_MSK = 8'h14;

  typedef enum logic [1:0] {AFS_LOW, AFS_HIGH, AFS_HOLD, AFS_TRACK} afs_sel_t;

  // control register layout, high bits first
  typedef struct packed {
    logic       follower;
    logic [1:0] ns_cur;
    logic [1:0] ns_volt;
    logic [1:0] nt_cur;
    logic [1:0] nt_volt;
    logic       pu_cur;
    logic       pu_volt;
  } afs_cfg_t;
  localparam afs_cfg_t CFG_RST = afs_cfg_t'{1'b0, 2'h2, 2'h2, 2'h2, 2'h2, 1'b0, 1'b0};

  typedef struct packed {
    afs_sel_t volt;
    afs_sel_t cur;
  } afs_out_t;

  localparam int unsigned IRQ_W = 3;
  localparam logic [IRQ_W-1:0] IRQ_FIRST = 3'h1;
  localparam logic [IRQ_W-1:0] IRQ_NT    = 3'h2;
  localparam logic [IRQ_W-1:0] IRQ_NS    = 3'h4;
endpackage
`default_nettype wire

// File: design/afs_timer.sv
// continuous-absence timer counted in 5 ms ticks
// assumes tick is a one-cycle enable and absent is synchronous
`default_nettype none
module afs_timer
  import afs_pkg::*;
#(
  parameter int unsigned W = DELAY_W
) (
  // clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // condition
  input  wire logic         absent,
  input  wire logic         tick,
  input  wire logic [W-1:0] delay,
  // result
  output var  logic         expired
);
  logic [W-1:0] cnt_reg;
  wire          at_limit = (cnt_reg >= delay);

  // any presence restarts the count
  always_ff @(posedge aclk) begin
    if (!aresetn || !absent) begin
      cnt_reg <= '0;
      expired <= 1'b0;
    end else begin
      if (tick && !at_limit) cnt_reg <= cnt_reg + 1'b1;
      expired <= at_limit && (tick || expired);
    end
  end
endmodule
`default_nettype wire

// File: design/afs_top.sv
// analog output fallback selector with AXI4-Lite registers
// assumes engine strobes are on aclk; sync_present comes from a pin
`default_nettype none
module afs_top
  import afs_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = STEP_CYCLES
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // measurement engine
  input  wire logic        meas_done,
  input  wire logic        target_found_indicator,
  input  wire logic        sync_present,
  // analog stage
  output var  afs_out_t    level_sel,
  output var  logic        irq
);
  afs_cfg_t             cfg_reg;
  logic [DELAY_W-1:0]   ntdly_reg, nsdly_reg;
  logic [IRQ_W-1:0]     ist_reg, imsk_reg;
  logic                 first_done_reg;
  logic                 sync_s1_reg, sync_s2_reg;
  logic [31:0]          div_reg;
  logic                 tick_reg;
  logic                 nt_exp, ns_exp, nt_exp_d_reg, ns_exp_d_reg;
  logic                 nt_lat_reg, ns_lat_reg;

  // sync pin is asynchronous to aclk
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_s1_reg <= 1'b0;
      sync_s2_reg <= 1'b0;
    end else begin
      sync_s1_reg <= sync_present;
      sync_s2_reg <= sync_s1_reg;
    end
  end

  // 5 ms step enable
  wire div_wrap = (div_reg >= TICK_CYCLES - 1);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_reg  <= '0;
      tick_reg <= 1'b0;
    end else begin
      div_reg  <= div_wrap ? '0 : div_reg + 32'h1;
      tick_reg <= div_wrap;
    end
  end

  afs_timer #(.W(DELAY_W)) u_nt (
    .aclk    (aclk),
    .aresetn (aresetn),
    .absent  (!target_found_indicator),
    .tick    (tick_reg),
    .delay   (ntdly_reg),
    .expired (nt_exp)
  );

  // single no-sync delay for all outputs
  afs_timer #(.W(DELAY_W)) u_ns (
    .aclk    (aclk),
    .aresetn (aresetn),
    .absent  (cfg_reg.follower && !sync_s2_reg),
    .tick    (tick_reg),
    .delay   (nsdly_reg),
    .expired (ns_exp)
  );

  wire nt_rise = nt_exp && !nt_exp_d_reg;
  wire ns_rise = ns_exp && !ns_exp_d_reg;

  // a fallback stays until the next completed measurement after its cause clears
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      first_done_reg <= 1'b0;
      nt_exp_d_reg   <= 1'b0;
      ns_exp_d_reg   <= 1'b0;
      nt_lat_reg     <= 1'b0;
      ns_lat_reg     <= 1'b0;
    end else begin
      nt_exp_d_reg <= nt_exp;
      ns_exp_d_reg <= ns_exp;
      if (meas_done) first_done_reg <= 1'b1;
      if (nt_exp) nt_lat_reg <= 1'b1;
      else if (meas_done) nt_lat_reg <= 1'b0;
      if (ns_exp) ns_lat_reg <= 1'b1;
      else if (meas_done) ns_lat_reg <= 1'b0;
    end
  end

  function automatic afs_sel_t pick(input logic [1:0] opt);
    pick = afs_sel_t'(opt);
  endfunction

  // priority: power-up, then lost sync, then no target, else track
  afs_out_t sel_next;
  always_comb begin
    sel_next.volt = AFS_TRACK;
    sel_next.cur  = AFS_TRACK;
    if (!first_done_reg) begin
      sel_next.volt = cfg_reg.pu_volt ? AFS_HIGH : AFS_LOW;
      sel_next.cur  = cfg_reg.pu_cur ? AFS_HIGH : AFS_LOW;
    end else if (ns_lat_reg) begin
      sel_next.volt = pick(cfg_reg.ns_volt);
      sel_next.cur  = pick(cfg_reg.ns_cur);
    end else if (nt_lat_reg) begin
      sel_next.volt = pick(cfg_reg.nt_volt);
      sel_next.cur  = pick(cfg_reg.nt_cur);
    end
  end

  // events: first measurement, no-target timeout, no-sync timeout
  wire [IRQ_W-1:0] ev = {ns_rise, nt_rise, meas_done && !first_done_reg};

  // axi4-lite write path: address and data may come in either order
  logic       aw_held_reg, w_held_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  wire        wr_go = aw_held_reg && w_held_reg && !s_axi_bvalid;
  wire [31:0] wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}}, {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
  wire        wr_ctrl = wr_go && (aw_addr_reg == OFF_CTRL);
  wire        wr_nt   = wr_go && (aw_addr_reg == OFF_NTDLY);
  wire        wr_ns   = wr_go && (aw_addr_reg == OFF_NSDLY);
  wire        wr_ist  = wr_go && (aw_addr_reg == OFF_IRQ_ST);
  wire        wr_msk  = wr_go && (aw_addr_reg == OFF_IRQ_MSK);
  wire        wr_hit  = wr_ctrl || wr_nt || wr_ns || wr_ist || wr_msk;
  wire [31:0] cfg_w   = (32'(cfg_reg) & ~wmask) | (w_data_reg & wmask);
  wire [31:0] nt_w    = (32'(ntdly_reg) & ~wmask) | (w_data_reg & wmask);
  wire [31:0] ns_w    = (32'(nsdly_reg) & ~wmask) | (w_data_reg & wmask);
  wire [31:0] msk_w   = (32'(imsk_reg) & ~wmask) | (w_data_reg & wmask);
  wire [IRQ_W-1:0] clr = wr_ist ? (w_data_reg[IRQ_W-1:0] & wmask[IRQ_W-1:0]) : '0;
  wire [DELAY_W-1:0] nt_cap = (nt_w[DELAY_W-1:0] > NT_DELAY_LIMIT) ? NT_DELAY_LIMIT : nt_w[DELAY_W-1:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      aw_addr_reg   <= 8'h00;
      w_data_reg    <= 32'h0;
      w_strb_reg    <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end else if (wr_go) aw_held_reg <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end else if (wr_go) w_held_reg <= 1'b0;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? 2'h0 : 2'h2;
      end else if (s_axi_bready) s_axi_bvalid <= 1'b0;
    end
  end

  // readies come from flops; low at the first edge after reset, high from the second
  wire aw_take      = s_axi_awvalid && s_axi_awready;
  wire w_take       = s_axi_wvalid && s_axi_wready;
  wire ar_take      = s_axi_arvalid && s_axi_arready;
  wire aw_held_next = aw_take || (aw_held_reg && !wr_go);
  wire w_held_next  = w_take || (w_held_reg && !wr_go);
  wire rvalid_next  = ar_take || (s_axi_rvalid && !s_axi_rready);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_next;
      s_axi_wready  <= !w_held_next;
      s_axi_arready <= !rvalid_next;
    end
  end

  // register file
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_reg   <= CFG_RST;
      ntdly_reg <= NT_DELAY_RST;
      nsdly_reg <= NS_DELAY_RST;
      imsk_reg  <= '0;
      ist_reg   <= '0;
    end else begin
      if (wr_ctrl) cfg_reg <= afs_cfg_t'(cfg_w[$bits(afs_cfg_t)-1:0]);
      if (wr_nt) ntdly_reg <= nt_cap;
      if (wr_ns) nsdly_reg <= ns_w[DELAY_W-1:0];
      if (wr_msk) imsk_reg <= msk_w[IRQ_W-1:0];
      // a new event wins over a clear in the same cycle
      ist_reg <= (ist_reg & ~clr) | ev;
    end
  end

  // axi4-lite read path
  wire [31:0] stat_w = {28'h0, ns_lat_reg, nt_lat_reg, first_done_reg, sync_s2_reg};
  wire [7:0]  ra = s_axi_araddr;
  wire        rd_hit = (ra == OFF_CTRL) || (ra == OFF_NTDLY) || (ra == OFF_NSDLY) ||
                       (ra == OFF_STATUS) || (ra == OFF_IRQ_ST) || (ra == OFF_IRQ_MSK);
  wire [31:0] rd_val = (ra == OFF_CTRL)   ? 32'(cfg_reg) :
                       (ra == OFF_NTDLY)  ? 32'(ntdly_reg) :
                       (ra == OFF_NSDLY)  ? 32'(nsdly_reg) :
                       (ra == OFF_STATUS) ? stat_w :
                       (ra == OFF_IRQ_ST) ? 32'(ist_reg) :
                       (ra == OFF_IRQ_MSK) ? 32'(imsk_reg) : 32'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_val;
      s_axi_rresp  <= rd_hit ? 2'h0 : 2'h2;
    end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
  end

  // outputs registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_sel <= afs_out_t'{AFS_LOW, AFS_LOW};
      irq       <= 1'b0;
    end else begin
      level_sel <= sel_next;
      irq       <= |(ist_reg & imsk_reg);
    end
  end

  a_powerup_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    !first_done_reg && !cfg_reg.pu_volt |=> level_sel.volt == AFS_LOW)
    else $error("power-up voltage not low");
  a_powerup_cur: assert property (@(posedge aclk) disable iff (!aresetn)
    !first_done_reg && cfg_reg.pu_cur |=> level_sel.cur == AFS_HIGH)
    else $error("power-up current not high");
  a_first_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    first_done_reg |=> first_done_reg)
    else $error("power-up level came back");
  a_nt_volt: assert property (@(posedge aclk) disable iff (!aresetn)
    first_done_reg && nt_lat_reg && !ns_lat_reg |=> level_sel.volt == $past(pick(cfg_reg.nt_volt)))
    else $error("no-target voltage wrong");
  a_nt_cur: assert property (@(posedge aclk) disable iff (!aresetn)
    first_done_reg && nt_lat_reg && !ns_lat_reg |=> level_sel.cur == $past(pick(cfg_reg.nt_cur)))
    else $error("no-target current wrong");
  a_nt_reset: assert property (@(posedge aclk) disable iff (!aresetn)
    target_found_indicator |=> !nt_exp)
    else $error("no-target timer not restarted");
  a_nt_clamp: assert property (@(posedge aclk) disable iff (!aresetn)
    ntdly_reg <= NT_DELAY_LIMIT)
    else $error("no-target delay above its limit");
  a_ns_volt: assert property (@(posedge aclk) disable iff (!aresetn)
    first_done_reg && ns_lat_reg |=> level_sel.volt == $past(pick(cfg_reg.ns_volt)))
    else $error("no-sync voltage wrong");
  a_ns_cur: assert property (@(posedge aclk) disable iff (!aresetn)
    first_done_reg && ns_lat_reg |=> level_sel.cur == $past(pick(cfg_reg.ns_cur)))
    else $error("no-sync current wrong");
  a_ns_master: assert property (@(posedge aclk) disable iff (!aresetn)
    !cfg_reg.follower |=> !ns_exp)
    else $error("no-sync fired on master");
  a_resume_track: assert property (@(posedge aclk) disable iff (!aresetn)
    first_done_reg && !nt_exp && !ns_exp && meas_done |=> ##1 level_sel == afs_out_t'{AFS_TRACK, AFS_TRACK})
    else $error("tracking not resumed");
  a_event_wins: assert property (@(posedge aclk) disable iff (!aresetn)
    ev != '0 |=> (ist_reg & $past(ev)) == $past(ev))
    else $error("interrupt event lost");
  a_irq_follows: assert property (@(posedge aclk) disable iff (!aresetn)
    |(ist_reg & imsk_reg) |=> irq)
    else $error("interrupt output not raised");
  a_bresp_done: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not retired");
  a_rresp_done: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response not retired");
  c_first: cover property (@(posedge aclk) meas_done && !first_done_reg);
  c_nt: cover property (@(posedge aclk) nt_rise);
  c_ns: cover property (@(posedge aclk) ns_rise);
  c_irq: cover property (@(posedge aclk) irq);
  c_resume: cover property (@(posedge aclk) nt_lat_reg && meas_done && !nt_exp);
endmodule
`default_nettype wire

// File: verification/afs_engine_model.sv
// stand-in for the measurement engine and the sync pin of the leader sensor
// assumes bench commands change just after a rising aclk edge
`default_nettype none
module afs_engine_model (
  // clock
  input  wire logic aclk,
  // commands from the bench
  input  wire logic want_target,
  input  wire logic want_sync,
  input  wire logic fire,
  // engine outputs
  output var  logic meas_done,
  output var  logic target_found_indicator,
  output var  logic sync_present
);
  timeunit 1ns;
  timeprecision 1ps;
  // one-cycle completion strobe per request; levels follow commands
  always @(posedge aclk) begin
    meas_done <= fire;
    target_found_indicator <= want_target;
    sync_present <= want_sync;
  end
endmodule
`default_nettype wire

// File: verification/afs_top_bench.sv
// self-checking bench for the analog output fallback selector
// assumes afs_top with a 4-cycle tick and the engine stand-in beside it
`default_nettype none
module afs_top_bench
  import afs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned TK = 4;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        meas_done, target_found_indicator, sync_present;
  logic        want_target = 1'b1, want_sync = 1'b1, fire = 1'b0;
  afs_out_t    level_sel;
  afs_sel_t    v, c;
  int          miscompares = 0, cmp_count = 0, cycles = 0;

  afs_top #(.TICK_CYCLES(TK)) dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .meas_done, .target_found_indicator, .sync_present, .level_sel, .irq);
  afs_engine_model eng_u (.aclk, .want_target, .want_sync, .fire, .meas_done, .target_found_indicator,
    .sync_present);

  always #2.5 aclk = ~aclk;
  // the whole run needs about 350 cycles
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 6000) begin
      miscompares++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic lv(input string nm, input afs_sel_t ev, input afs_sel_t ec);
    check(nm, {28'h0, level_sel}, {28'h0, ev, ec});
  endtask

  function automatic logic [31:0] cf(logic fl, afs_sel_t nsc, nsv, ntc, ntv, logic puc, puv);
    return {21'h0, fl, nsc, nsv, ntc, ntv, puc, puv};
  endfunction

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic meas();
    repeat (4) @(posedge aclk);
    fire <= 1'b1;
    @(posedge aclk);
    fire <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    lv("lvl_rst", AFS_LOW, AFS_LOW);
    check("irq_rst", {31'h0, irq}, 32'h0);
    rdr(OFF_CTRL);
    check("ctrl_rst", rd, cf(1'b0, AFS_HOLD, AFS_HOLD, AFS_HOLD, AFS_HOLD, 1'b0, 1'b0));
    check("ok_rresp", {30'h0, rsp}, 32'h0);
    rdr(OFF_NTDLY);
    check("ntdly_rst", rd, 32'h0);
    rdr(OFF_NSDLY);
    check("nsdly_rst", rd, 32'h0);
    wr(OFF_CTRL, cf(1'b0, AFS_HOLD, AFS_HOLD, AFS_HOLD, AFS_HOLD, 1'b0, 1'b1));
    check("ok_bresp", {30'h0, rsp}, 32'h0);
    repeat (3) @(posedge aclk);
    lv("pu_volt", AFS_HIGH, AFS_LOW);
    wr(OFF_CTRL, cf(1'b0, AFS_HOLD, AFS_HOLD, AFS_HOLD, AFS_HOLD, 1'b1, 1'b0));
    repeat (3) @(posedge aclk);
    lv("pu_cur", AFS_LOW, AFS_HIGH);
    meas();
    lv("first_meas", AFS_TRACK, AFS_TRACK);
    wr(OFF_IRQ_MSK, 32'h1);
    repeat (3) @(posedge aclk);
    check("irq_set", {31'h0, irq}, 32'h1);
    wr(OFF_IRQ_ST, 32'h1);
    repeat (3) @(posedge aclk);
    check("irq_clr", {31'h0, irq}, 32'h0);
    // the low, high and hold codes on both outputs, each pair different
    for (int i = 0; i < 3; i++) begin
      v = afs_sel_t'(i);
      c = afs_sel_t'((i + 1) % 3);
      wr(OFF_CTRL, cf(1'b0, AFS_HOLD, AFS_HOLD, c, v, 1'b0, 1'b0));
      want_target <= 1'b0;
      repeat (6 * TK) @(posedge aclk);
      lv("nt_fb", v, c);
      want_target <= 1'b1;
      meas();
      lv("nt_back", AFS_TRACK, AFS_TRACK);
    end
    wr(OFF_NTDLY, 32'hFFFF);
    rdr(OFF_NTDLY);
    check("nt_clamp", rd, 32'hFFF0);
    wr(OFF_NTDLY, 32'h6);
    wr(OFF_IRQ_ST, 32'h7);
    // absence broken by a short detection must start over
    want_target <= 1'b0;
    repeat (3 * TK) @(posedge aclk);
    want_target <= 1'b1;
    repeat (2 * TK) @(posedge aclk);
    want_target <= 1'b0;
    repeat (4 * TK) @(posedge aclk);
    lv("nt_early", AFS_TRACK, AFS_TRACK);
    repeat (5 * TK) @(posedge aclk);
    lv("nt_late", AFS_HOLD, AFS_LOW);
    rdr(OFF_IRQ_ST);
    check("nt_event", rd, 32'h2);
    want_target <= 1'b1;
    meas();
    wr(OFF_NSDLY, 32'h2);
    rdr(OFF_NSDLY);
    check("nsdly", rd, 32'h2);
    want_sync <= 1'b0;
    repeat (8 * TK) @(posedge aclk);
    lv("ns_leader", AFS_TRACK, AFS_TRACK);
    wr(OFF_CTRL, cf(1'b1, AFS_LOW, AFS_HIGH, AFS_HOLD, AFS_HOLD, 1'b0, 1'b0));
    repeat (6 * TK) @(posedge aclk);
    lv("ns_fb", AFS_HIGH, AFS_LOW);
    rdr(OFF_STATUS);
    check("ns_status", rd, 32'hA);
    rdr(OFF_IRQ_ST);
    check("ns_event", rd, 32'h6);
    want_sync <= 1'b1;
    meas();
    lv("ns_back", AFS_TRACK, AFS_TRACK);
    rdr(8'h20);
    check("bad_rresp", {30'h0, rsp}, 32'h2);
    check("bad_rdata", rd, 32'h0);
    wr(8'h20, 32'hFFFFFFFF);
    check("bad_bresp", {30'h0, rsp}, 32'h2);
    print_verdict();
  end
endmodule
`default_nettype wire
